// ### fxp_pkg.sv
// Purpose : Shared constants, field layouts and carriers of the fixed-point pipeline front end
// Assumes : 32-bit instruction words, eight slots per fetch packet, eight functional units
// Notes   : Instruction class and unit fields are the pipeline's own routing fields
package fxp_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int FXP_SLOTS   = 8;
  localparam int FXP_UNITS   = 8;
  localparam int FXP_EXEC_N  = 5;
  localparam int FXP_WORD_W  = 32;
  localparam int FXP_ADDR_W  = 32;
  localparam int FXP_SLOT_W  = 3;
  localparam int FXP_REG_W   = 5;
  localparam int FXP_CLS_W   = 3;
  localparam int FXP_LEN_W   = 3;

  localparam logic [FXP_ADDR_W-1:0] FXP_FP_BYTES   = 32'h00000020;
  localparam logic [FXP_ADDR_W-1:0] FXP_FP_ALIGN   = 32'hffffffe0;
  localparam logic [FXP_ADDR_W-1:0] FXP_RESET_ADDR = 32'h00000000;
  localparam int                    FXP_SLOT_LSB   = 2;

  // ----------------------------------------
  // Instruction word fields
  // ----------------------------------------
  localparam int FXP_PAR_BIT  = 0;
  localparam int FXP_CLS_LSB  = 2;
  localparam int FXP_UNIT_LSB = 5;
  localparam int FXP_SRC1_LSB = 13;
  localparam int FXP_SRC2_LSB = 18;
  localparam int FXP_DST_LSB  = 23;

  localparam logic [FXP_WORD_W-1:0] FXP_NOP_MASK = 32'hfffffffe;
  localparam logic [FXP_WORD_W-1:0] FXP_NOP_CODE = 32'h00000000;

  // ----------------------------------------
  // Instruction classes and their execute lengths
  // ----------------------------------------
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_SINGLE = 3'h0;
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_MPY    = 3'h1;
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_STORE  = 3'h2;
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_MPYX   = 3'h3;
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_LOAD   = 3'h4;
  localparam logic [FXP_CLS_W-1:0] FXP_CLS_BRANCH = 3'h5;

  localparam logic [FXP_LEN_W-1:0] FXP_LEN_SINGLE = 3'h1;
  localparam logic [FXP_LEN_W-1:0] FXP_LEN_MPY    = 3'h2;
  localparam logic [FXP_LEN_W-1:0] FXP_LEN_STORE  = 3'h3;
  localparam logic [FXP_LEN_W-1:0] FXP_LEN_MPYX   = 3'h4;
  localparam logic [FXP_LEN_W-1:0] FXP_LEN_LOAD   = 3'h5;

  function automatic logic [FXP_LEN_W-1:0] fxp_len(input logic [FXP_CLS_W-1:0] cls);
    logic [FXP_LEN_W-1:0] len;
    len = FXP_LEN_SINGLE;
    unique case (cls)
      FXP_CLS_MPY   : len = FXP_LEN_MPY;
      FXP_CLS_STORE : len = FXP_LEN_STORE;
      FXP_CLS_MPYX  : len = FXP_LEN_MPYX;
      FXP_CLS_LOAD  : len = FXP_LEN_LOAD;
      default       : len = FXP_LEN_SINGLE;
    endcase
    return len;
  endfunction

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic                  valid;
    logic [FXP_WORD_W-1:0] word;
  } fxp_slot_t;

  typedef struct packed {
    logic                 valid;
    logic [FXP_REG_W-1:0] src1;
    logic [FXP_REG_W-1:0] src2;
    logic [FXP_REG_W-1:0] dst;
    logic [FXP_CLS_W-1:0] cls;
  } fxp_dec_t;

  typedef struct packed {
    logic [FXP_EXEC_N-1:0] phase;
    logic                  lastPhase;
    logic                  memAddr;
  } fxp_exec_t;

endpackage

// ### fxp_pipeline.sv
// Purpose : Fetch, dispatch, decode and execute-phase sequencing of a fixed-point VLIW pipeline
// Assumes : Program memory is a registered read on clk_sys that holds its output while the address holds
// Notes   : No interlocks; every decode and execute phase lasts exactly one cycle, fetch phases hold during multi-packet dispatch
`timescale 1ns/100ps

module fxp_pipeline
  import fxp_pkg::*;
#(
  parameter int                    SLOTS      = FXP_SLOTS,      // Instructions per fetch packet
  parameter int                    UNITS      = FXP_UNITS,      // Functional units
  parameter logic [FXP_ADDR_W-1:0] RESET_ADDR = FXP_RESET_ADDR  // First fetch address
)
(
  input  wire logic                        clk_sys,       // System clock, 20 MHz
  input  wire logic                        rst_n,         // Asynchronous reset, active low
  input  wire logic                        branchTaken,   // Branch resolved true in first execute phase
  input  wire logic [FXP_ADDR_W-1:0]       branchTarget,  // Branch target byte address
  output logic      [FXP_ADDR_W-1:0]       pmemAddr,      // Fetch packet address to program memory
  output logic                             pmemReq,       // Pulse: new address presented
  input  wire logic [SLOTS*FXP_WORD_W-1:0] pmemPacket,    // Returned fetch packet, slot 0 lowest
  input  wire logic [UNITS-1:0]            condFalse,     // Per unit: condition false in first execute
  output fxp_slot_t [UNITS-1:0]            dispatchUnit,  // Dispatch phase contents per unit
  output fxp_dec_t  [UNITS-1:0]            decodeUnit,    // Decode phase contents per unit
  output fxp_exec_t [UNITS-1:0]            execUnit,      // Execute phase occupancy per unit
  output logic                             fetchHeld      // Fetch waiting on multi-packet dispatch
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (SLOTS != FXP_SLOTS)
  begin : g_chkSlots
    $error("fxp_pipeline: fetch packet must hold eight slots");
  end
  if (UNITS != (1 << FXP_SLOT_W))
  begin : g_chkUnits
    $error("fxp_pipeline: unit count must match the unit field");
  end

  // ----------------------------------------
  // Fetch phase registers
  // ----------------------------------------
  logic [FXP_ADDR_W-1:0]       pc_reg;
  logic [FXP_ADDR_W-1:0]       pc_next;
  logic                        pgValid_reg;
  logic                        psValid_reg;
  logic                        pwValid_reg;
  logic                        prValid_reg;
  logic [FXP_SLOT_W-1:0]       psSlot_reg;
  logic [FXP_SLOT_W-1:0]       pwSlot_reg;
  logic [FXP_ADDR_W-1:0]       pmemAddr_reg;
  logic                        pmemReq_reg;
  logic [SLOTS*FXP_WORD_W-1:0] prPacket_reg;
  logic [SLOTS-1:0]            remain_reg;
  logic [SLOTS-1:0]            remain_next;
  logic                        brPend_reg;
  logic [FXP_ADDR_W-1:0]       brAddr_reg;
  logic                        fetchHeld_reg;
  logic [SLOTS*FXP_WORD_W-1:0] pwPacket_reg;
  logic                        pwFresh_reg;

  wire logic [SLOTS-1:0] epMask;
  wire logic             dpLast;
  wire logic             advance;
  wire logic             useBranch;
  wire logic [FXP_ADDR_W-1:0] brSel;

  // Fetch moves only when receive is empty or its packet is fully dispatched
  assign advance   = !prValid_reg || dpLast;
  assign useBranch = branchTaken || brPend_reg;
  assign brSel     = branchTaken ? branchTarget : brAddr_reg;
  assign pc_next   = useBranch ? brSel : ((pc_reg & FXP_FP_ALIGN) + FXP_FP_BYTES);

  // ----------------------------------------
  // Program address generate
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg      <= RESET_ADDR;
      pgValid_reg <= 1'b0;
      brPend_reg  <= 1'b0;
      brAddr_reg  <= FXP_RESET_ADDR;
    end
    else
    begin
      pgValid_reg <= 1'b1;
      if (advance && pgValid_reg)
      begin
        pc_reg     <= pc_next;
        brPend_reg <= 1'b0;
      end
      else if (branchTaken)
      begin
        brPend_reg <= 1'b1;
        brAddr_reg <= branchTarget;
      end
    end
  end

  // ----------------------------------------
  // Address send, access wait, packet receive
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psValid_reg   <= 1'b0;
      pwValid_reg   <= 1'b0;
      prValid_reg   <= 1'b0;
      psSlot_reg    <= '0;
      pwSlot_reg    <= '0;
      pmemAddr_reg  <= FXP_RESET_ADDR;
      pmemReq_reg   <= 1'b0;
      prPacket_reg  <= '0;
      fetchHeld_reg <= 1'b0;
    end
    else
    begin
      pmemReq_reg   <= advance && pgValid_reg;
      fetchHeld_reg <= !advance;
      if (advance)
      begin
        psValid_reg  <= pgValid_reg;
        pwValid_reg  <= psValid_reg;
        prValid_reg  <= pwValid_reg;
        pmemAddr_reg <= pc_reg & FXP_FP_ALIGN;
        psSlot_reg   <= pc_reg[FXP_SLOT_LSB +: FXP_SLOT_W];
        pwSlot_reg   <= psSlot_reg;
        prPacket_reg <= pwFresh_reg ? pmemPacket : pwPacket_reg;
      end
    end
  end

  // ----------------------------------------
  // Access wait: keep the memory answer
  // ----------------------------------------
  // Memory moves to the next address one cycle into wait; held fetch needs this copy
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwFresh_reg  <= 1'b0;
      pwPacket_reg <= '0;
    end
    else
    begin
      pwFresh_reg <= advance;
      if (pwFresh_reg)
      begin
        pwPacket_reg <= pmemPacket;
      end
    end
  end

  // ----------------------------------------
  // Dispatch: execute packet boundaries
  // ----------------------------------------
  logic [SLOTS-1:0] epMask_c;
  logic             epDone_c;

  // Take remaining slots from the lowest up to the first cleared parallel bit
  always_comb
  begin
    epMask_c = '0;
    epDone_c = 1'b0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (remain_reg[i] && !epDone_c)
      begin
        epMask_c[i] = 1'b1;
        if (!prPacket_reg[i*FXP_WORD_W + FXP_PAR_BIT])
        begin
          epDone_c = 1'b1;
        end
      end
    end
  end

  assign epMask = epMask_c;
  assign dpLast = prValid_reg && ((remain_reg & ~epMask) == '0);

  always_comb
  begin
    remain_next = remain_reg & ~epMask;
    if (advance)
    begin
      remain_next = pwValid_reg ? (SLOTS'('1) << pwSlot_reg) : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain_reg <= '0;
    end
    else
    begin
      remain_reg <= remain_next;
    end
  end

  // ----------------------------------------
  // Dispatch: routing to functional units
  // ----------------------------------------
  fxp_slot_t [UNITS-1:0] route_c;
  fxp_slot_t [UNITS-1:0] dispatch_reg;

  always_comb
  begin
    logic [FXP_WORD_W-1:0] w;
    w       = '0;
    route_c = '0;
    for (int s = 0; s < SLOTS; s++)
    begin
      w = prPacket_reg[s*FXP_WORD_W +: FXP_WORD_W];
      if (prValid_reg && epMask[s] && ((w & FXP_NOP_MASK) != FXP_NOP_CODE))
      begin
        route_c[w[FXP_UNIT_LSB +: FXP_SLOT_W]].valid = 1'b1;
        route_c[w[FXP_UNIT_LSB +: FXP_SLOT_W]].word  = w;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dispatch_reg <= '0;
    end
    else
    begin
      dispatch_reg <= route_c;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  fxp_dec_t [UNITS-1:0] decode_reg;
  fxp_dec_t [UNITS-1:0] decode_next;

  always_comb
  begin
    for (int u = 0; u < UNITS; u++)
    begin
      decode_next[u].valid = dispatch_reg[u].valid;
      decode_next[u].src1  = dispatch_reg[u].word[FXP_SRC1_LSB +: FXP_REG_W];
      decode_next[u].src2  = dispatch_reg[u].word[FXP_SRC2_LSB +: FXP_REG_W];
      decode_next[u].dst   = dispatch_reg[u].word[FXP_DST_LSB +: FXP_REG_W];
      decode_next[u].cls   = dispatch_reg[u].word[FXP_CLS_LSB +: FXP_CLS_W];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decode_reg <= '0;
    end
    else
    begin
      decode_reg <= decode_next;
    end
  end

  // ----------------------------------------
  // Execute phases, one shift chain per unit
  // ----------------------------------------
  fxp_exec_t [UNITS-1:0] exec_reg;

  for (genvar u = 0; u < UNITS; u++)
  begin : g_exec
    logic [FXP_CLS_W-1:0]  cls_reg [FXP_EXEC_N];
    logic [FXP_EXEC_N-1:0] phase_next;
    logic [FXP_EXEC_N-1:0] last_next;
    wire logic             isLdSt;
    wire logic [FXP_LEN_W-1:0] newLen;

    assign newLen = fxp_len(decode_reg[u].cls);
    assign isLdSt = (cls_reg[0] == FXP_CLS_LOAD) || (cls_reg[0] == FXP_CLS_STORE);

    always_comb
    begin
      phase_next    = '0;
      last_next     = '0;
      phase_next[0] = decode_reg[u].valid;
      last_next[0]  = decode_reg[u].valid && (newLen == FXP_LEN_SINGLE);
      for (int k = 1; k < FXP_EXEC_N; k++)
      begin
        phase_next[k] = exec_reg[u].phase[k-1]
                        && (fxp_len(cls_reg[k-1]) > FXP_LEN_W'(k))
                        && !((k == 1) && condFalse[u]);
        last_next[k]  = phase_next[k] && (fxp_len(cls_reg[k-1]) == FXP_LEN_W'(k + 1));
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        exec_reg[u] <= '0;
        for (int k = 0; k < FXP_EXEC_N; k++)
        begin
          cls_reg[k] <= FXP_CLS_SINGLE;
        end
      end
      else
      begin
        exec_reg[u].phase     <= phase_next;
        exec_reg[u].lastPhase <= |last_next;
        exec_reg[u].memAddr   <= exec_reg[u].phase[0] && isLdSt && !condFalse[u];
        cls_reg[0]            <= decode_reg[u].cls;
        for (int k = 1; k < FXP_EXEC_N; k++)
        begin
          cls_reg[k] <= cls_reg[k-1];
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Fixed timing throughout: no stall reaches dispatch, decode or execute
  assign pmemAddr     = pmemAddr_reg;
  assign pmemReq      = pmemReq_reg;
  assign dispatchUnit = dispatch_reg;
  assign decodeUnit   = decode_reg;
  assign execUnit     = exec_reg;
  assign fetchHeld    = fetchHeld_reg;

endmodule

// ### fxp_pipeline_assertions.sv
// Purpose : Port-level checks of the pipeline front end
// Assumes : One clock domain, reset active low
// Notes   : Bound to every pipeline instance
`timescale 1ns/100ps
module fxp_pipeline_assertions
  import fxp_pkg::*;
#(
  parameter int                    SLOTS      = FXP_SLOTS,
  parameter int                    UNITS      = FXP_UNITS,
  parameter logic [FXP_ADDR_W-1:0] RESET_ADDR = FXP_RESET_ADDR
)
(
  input wire logic                        clk_sys,      // Clock
  input wire logic                        rst_n,        // Reset
  input wire logic                        branchTaken,  // Branch pulse
  input wire logic [FXP_ADDR_W-1:0]       branchTarget, // Branch target
  input wire logic [FXP_ADDR_W-1:0]       pmemAddr,     // Fetch address
  input wire logic                        pmemReq,      // Address strobe
  input wire logic [SLOTS*FXP_WORD_W-1:0] pmemPacket,   // Fetch packet
  input wire logic [UNITS-1:0]            condFalse,    // Condition false
  input wire fxp_slot_t [UNITS-1:0]       dispatchUnit, // Dispatch phase
  input wire fxp_dec_t  [UNITS-1:0]       decodeUnit,   // Decode phase
  input wire fxp_exec_t [UNITS-1:0]       execUnit,     // Execute phases
  input wire logic                        fetchHeld     // Fetch held
);
  wire logic [UNITS-1:0] dispValid;
  wire logic [UNITS-1:0] execBusy;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Reset and fetch side
  // ----------------------------------------
  a_reset_empty :
    assert property ($rose(rst_n) |-> (dispValid == '0 && execBusy == '0) [*5])
    else $error("Pipeline not empty after reset");
  a_first_fetch :
    assert property ($rose(rst_n) |-> !pmemReq ##1 !pmemReq ##1 pmemReq && pmemAddr == (RESET_ADDR & FXP_FP_ALIGN))
    else $error("First fetch address late or wrong");
  a_req_aligned :
    assert property (pmemReq |-> (pmemAddr & ~FXP_FP_ALIGN) == '0)
    else $error("Fetch address not packet aligned");
  a_addr_holds :
    assert property (!pmemReq |-> $stable(pmemAddr))
    else $error("Fetch address moved without strobe");
  a_held_no_req :
    assert property (fetchHeld |-> !pmemReq)
    else $error("Fetch strobe while fetch held");

  // ----------------------------------------
  // Per unit phases
  // ----------------------------------------
  for (genvar u = 0; u < UNITS; u++)
  begin : g_unit
    assign dispValid[u] = dispatchUnit[u].valid;
    assign execBusy[u]  = |execUnit[u].phase;
    a_nop_blocked :
      assert property (dispatchUnit[u].valid |-> (dispatchUnit[u].word & FXP_NOP_MASK) != FXP_NOP_CODE)
      else $error("No-operation word dispatched");
    a_fields_match :
      assert property (dispatchUnit[u].valid |=> decodeUnit[u].valid
        && decodeUnit[u].src1 == $past(dispatchUnit[u].word[FXP_SRC1_LSB +: FXP_REG_W])
        && decodeUnit[u].src2 == $past(dispatchUnit[u].word[FXP_SRC2_LSB +: FXP_REG_W])
        && decodeUnit[u].dst == $past(dispatchUnit[u].word[FXP_DST_LSB +: FXP_REG_W])
        && decodeUnit[u].cls == $past(dispatchUnit[u].word[FXP_CLS_LSB +: FXP_CLS_W]))
      else $error("Decode fields do not follow dispatch");
    a_exec_follows :
      assert property (decodeUnit[u].valid |=> execUnit[u].phase[0])
      else $error("Decode not followed by first execute phase");
    a_kill_stops :
      assert property (execUnit[u].phase[0] && condFalse[u] |=> !execUnit[u].phase[1] && !execUnit[u].memAddr)
      else $error("Killed instruction went on");
    a_mem_phase :
      assert property (decodeUnit[u].valid && (decodeUnit[u].cls == FXP_CLS_LOAD
        || decodeUnit[u].cls == FXP_CLS_STORE) ##1 !condFalse[u] |=> execUnit[u].memAddr && execUnit[u].phase[1])
      else $error("Memory address not in second execute phase");
    a_load_span :
      assert property (decodeUnit[u].valid && decodeUnit[u].cls == FXP_CLS_LOAD ##1 !condFalse[u]
        |=> ##3 execUnit[u].phase[4] && execUnit[u].lastPhase)
      else $error("Load did not end in fifth execute phase");
    a_single_last :
      assert property (decodeUnit[u].valid && decodeUnit[u].cls == FXP_CLS_SINGLE
        |=> execUnit[u].phase[0] && execUnit[u].lastPhase)
      else $error("Single cycle class not last in first phase");
    a_phase_step :
      assert property (execUnit[u].phase[1] && !execUnit[u].lastPhase |=> execUnit[u].phase[2])
      else $error("Execute phase skipped or stalled");
  end
endmodule

bind fxp_pipeline fxp_pipeline_assertions #(
  .SLOTS      (SLOTS),
  .UNITS      (UNITS),
  .RESET_ADDR (RESET_ADDR)
) u_checker (
  .clk_sys      (clk_sys),
  .rst_n        (rst_n),
  .branchTaken  (branchTaken),
  .branchTarget (branchTarget),
  .pmemAddr     (pmemAddr),
  .pmemReq      (pmemReq),
  .pmemPacket   (pmemPacket),
  .condFalse    (condFalse),
  .dispatchUnit (dispatchUnit),
  .decodeUnit   (decodeUnit),
  .execUnit     (execUnit),
  .fetchHeld    (fetchHeld)
);

// ### fxp_pmem_model.sv
// Purpose : Program memory behind the fetch port
// Assumes : Sixteen packets, image written by the bench
// Notes   : Slow mode shows a garbage packet until late in the wait cycle
`timescale 1ns/100ps
module fxp_pmem_model
  import fxp_pkg::*;
(
  input  wire logic                            clk_sys,    // Clock
  input  wire logic [FXP_ADDR_W-1:0]           pmemAddr,   // Fetch address
  input  wire logic                            pmemReq,    // Address strobe
  input  wire logic                            memSlow,    // Late answer
  output logic      [FXP_SLOTS*FXP_WORD_W-1:0] pmemPacket  // Fetch packet
);
  localparam int IDX_LSB = 5;
  logic [FXP_SLOTS*FXP_WORD_W-1:0] image [16];
  logic [FXP_SLOTS*FXP_WORD_W-1:0] readPkt;

  initial pmemPacket = '0;

  always @(posedge clk_sys)
  begin
    if (pmemReq === 1'b1)
    begin
      readPkt = image[pmemAddr[IDX_LSB +: 4]];
      #1;
      if (memSlow)
      begin
        pmemPacket = ~readPkt;
        #39;
      end
      pmemPacket = readPkt;
    end
  end
endmodule

// ### fxp_pipeline_bench.sv
// Purpose : Self-checking bench of the pipeline front end
// Assumes : Memory image of sixteen packets, fetch runs sequentially
// Notes   : Dispatch stream is predicted from the image
`timescale 1ns/100ps
module fxp_pipeline_bench
  import fxp_pkg::*;
;
  localparam int DRV        = 2;
  localparam int RUN_CYCLES = 2000;
  logic                            clk_sys;
  logic                            rst_n;
  logic                            branchTaken;
  logic                            memSlow;
  logic                            sbOn;
  logic                            hit;
  logic [FXP_ADDR_W-1:0]           branchTarget;
  logic [FXP_ADDR_W-1:0]           pmemAddr;
  logic                            pmemReq;
  logic                            fetchHeld;
  logic [FXP_SLOTS*FXP_WORD_W-1:0] pmemPacket;
  logic [FXP_UNITS-1:0]            condFalse;
  logic [31:0]                     rngState;
  fxp_slot_t [FXP_UNITS-1:0]       dispatchUnit;
  fxp_dec_t  [FXP_UNITS-1:0]       decodeUnit;
  fxp_exec_t [FXP_UNITS-1:0]       execUnit;
  fxp_slot_t [FXP_UNITS-1:0]       expQ [$];
  int                              fails;
  int                              testsRun;
  int                              cyc;
  int                              relCyc;
  int                              seenDisp;

  fxp_pipeline i_dut (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .branchTaken  (branchTaken),
    .branchTarget (branchTarget),
    .pmemAddr     (pmemAddr),
    .pmemReq      (pmemReq),
    .pmemPacket   (pmemPacket),
    .condFalse    (condFalse),
    .dispatchUnit (dispatchUnit),
    .decodeUnit   (decodeUnit),
    .execUnit     (execUnit),
    .fetchHeld    (fetchHeld)
  );

  fxp_pmem_model i_pmem (
    .clk_sys    (clk_sys),
    .pmemAddr   (pmemAddr),
    .pmemReq    (pmemReq),
    .memSlow    (memSlow),
    .pmemPacket (pmemPacket)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nextRand();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  task automatic check(input string what, input logic [299:0] seen, input logic [299:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stopTest();
    if (fails == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected execute packets, one per dispatch cycle that routes a word, in fetch order
  function automatic void buildQueue();
    fxp_slot_t [FXP_UNITS-1:0] ep;
    logic [FXP_WORD_W-1:0]     w;
    expQ.delete();
    ep = '0;
    for (int n = 0; n < 160; n++)
      for (int s = 0; s < FXP_SLOTS; s++)
      begin
        w = i_pmem.image[n % 16][s*FXP_WORD_W +: FXP_WORD_W];
        if ((w & FXP_NOP_MASK) != FXP_NOP_CODE)
        begin
          ep[w[FXP_UNIT_LSB +: 3]].valid = 1'b1;
          ep[w[FXP_UNIT_LSB +: 3]].word  = w;
        end
        if (!w[FXP_PAR_BIT] || s == FXP_SLOTS-1)
        begin
          if (ep != '0)
            expQ.push_back(ep);
          ep = '0;
        end
      end
  endfunction

  task automatic doReset(input logic slowMem);
    rst_n    = 1'b0;
    memSlow  = slowMem;
    seenDisp = 0;
    buildQueue();
    repeat (8) @(posedge clk_sys);
    #DRV;
    rst_n  = 1'b1;
    relCyc = cyc;
  endtask

  // ----------------------------------------
  // Clock, stimulus and monitor
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always
  begin
    @(posedge clk_sys);
    #DRV;
    condFalse = FXP_UNITS'(nextRand());
  end

  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (rst_n && sbOn && dispatchUnit != '0)
    begin
      if (seenDisp < 4)
        check("dispatch cycle", cyc - relCyc, 6 + seenDisp);
      if (expQ.size() == 0)
        check("dispatch queue", 1'b1, 1'b0);
      else
        check("dispatch packet", dispatchUnit, expQ.pop_front());
      seenDisp++;
    end
  end

  initial
  begin
    #(RUN_CYCLES * 50);
    fails++;
    stopTest();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] w;
    int          nReq;
    rngState     = 32'h00010035;
    rst_n        = 1'b0;
    branchTaken  = 1'b0;
    branchTarget = '0;
    condFalse    = '0;
    memSlow      = 1'b0;
    sbOn         = 1'b1;
    fails        = 0;
    testsRun     = 0;
    cyc          = 0;
    relCyc       = 0;
    seenDisp     = 0;
    for (int p = 0; p < 16; p++)
      for (int s = 0; s < FXP_SLOTS; s++)
      begin
        r = nextRand();
        if (p < 4)
          w = {r[31:8] | 24'h000001, 3'(s), r[4:1], s != FXP_SLOTS-1};
        else if (r[3:0] == 4'h0)
          w = {31'h0, r[4]};
        else
          w = r | 32'h00000100;
        if (p == 4)
          w[FXP_PAR_BIT] = 1'b0;
        if (p == 5 && s == FXP_SLOTS-1)
          w[FXP_PAR_BIT] = 1'b1;
        i_pmem.image[p][s*FXP_WORD_W +: FXP_WORD_W] = w;
      end
    doReset(1'b0);
    repeat (400) @(posedge clk_sys);
    #DRV;
    doReset(1'b1);
    repeat (300) @(posedge clk_sys);
    #DRV;
    sbOn         = 1'b0;
    branchTaken  = 1'b1;
    branchTarget = 32'h00000148;
    @(posedge clk_sys);
    #DRV;
    branchTaken = 1'b0;
    hit  = 1'b0;
    nReq = 0;
    // Second strobe after the branch carries the target
    for (int k = 0; k < 20 && nReq < 2; k++)
    begin
      @(posedge clk_sys);
      if (pmemReq === 1'b1)
      begin
        nReq++;
        hit = (nReq == 2) && (pmemAddr === (32'h00000148 & FXP_FP_ALIGN));
      end
    end
    check("branch fetch", hit, 1'b1);
    stopTest();
  end
endmodule
